//--- fifo_ctl_pkg.sv
// Package: widths, depths, defaults and carriers for the FIFO port control.
// Assumes one system clock; every port pin is sampled into it by the top.
package fifo_ctl_pkg;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int DATA_W   = 36;           // Widest port
  localparam int DEPTH    = 8;            // Words of storage
  localparam int PTR_W    = 3;            // Index into storage
  localparam int LVL_W    = 4;            // Stored word count, 0..DEPTH
  localparam int TOT_W    = 5;            // Count plus output word
  localparam int OFS_W    = 4;            // Threshold offset width
  localparam int HALF_W   = 18;           // Half port width
  localparam int NINE_W   = 9;            // Byte plus parity width

  // ----------------------------------------------------------------------
  // Reset values and default offsets
  // ----------------------------------------------------------------------
  localparam logic [DATA_W-1:0] OUT_RESET = 36'h0_0000_0000;
  localparam logic [LVL_W-1:0]  DEPTH_LVL = 4'h8;
  localparam logic [LVL_W-1:0]  HALF_LVL  = 4'h4;
  // Index is {access select, select 1, select 0} caught in full reset
  localparam logic [7:0][OFS_W-1:0] DEFAULT_OFS = {
    4'h7, 4'h6, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0
  };

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic              full_reset_n;
    logic              partial_reset_n;
    logic              wclk;
    logic              wen_n;
    logic [DATA_W-1:0] wdata;
    logic              rclk;
    logic              ren_n;
    logic              retransmit_n;
    logic              offset_access_n;
    logic              serial_load_enable_n;
    logic              fall_through_or_serial_in;
    logic              oe_n;
    logic [1:0]        fsel;
    logic              flag_timing_select;
    logic              retransmit_timing_select;
    logic              bus_matching_sel;
    logic              write_port_width_sel;
    logic              read_port_width_sel;
    logic              big_endian_n;
    logic              parity_sel;
    logic              sync_read_sel;
    logic              sync_write_sel;
  } pins_t;

  typedef struct packed {
    logic fall_through_mode;     // 1: fall-through, 0: standard timing
    logic serial_prog;           // 1: serial offset loading
    logic sync_flags;            // 1: almost flags follow the port clocks
    logic normal_rt;             // 1: normal-latency retransmit
    logic bus_matching_sel;
    logic write_port_width_sel;
    logic read_port_width_sel;
    logic big_endian_n;
    logic parity_sel;
    logic async_read;
    logic async_write;
  } cfg_t;

  localparam cfg_t CFG_RESET = '{default: 1'b0};

endpackage

//--- word_fifo.sv
// Storage of the buffer: a flop array with valid/ready on both sides.
// Assumes the caller never rewinds after the write pointer has wrapped.
`timescale 1ns/1ps
module word_fifo #(
  parameter int W  = 36,
  parameter int D  = 8,
  parameter int AW = 3
) (
  input  wire logic         clk,        // System clock
  input  wire logic         rst_n,      // Synchronous reset, active low
  input  wire logic         clear,      // Zero both pointers
  input  wire logic         rewind,     // Read pointer back to zero
  input  wire logic         in_valid,   // Word offered
  output logic              in_ready,   // Space for a word
  input  wire logic [W-1:0] in_data,    // Word to store
  output logic              out_valid,  // Word available
  input  wire logic         out_ready,  // Word taken
  output logic [W-1:0]      out_data,   // Head word
  output logic [AW:0]       level       // Stored words
);
  logic [W-1:0] mem [D];
  logic [AW:0]  wr_ptr;
  logic [AW:0]  rd_ptr;

  // ------------------------------------------------------------------
  // Status
  // ------------------------------------------------------------------
  assign level     = wr_ptr - rd_ptr;
  assign in_ready  = level != (AW+1)'(D);
  assign out_valid = level != '0;
  assign out_data  = mem[rd_ptr[AW-1:0]];

  // Pointers; the extra top bit tells full from empty
  always_ff @(posedge clk) begin
    if (!rst_n || clear) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (in_valid && in_ready) wr_ptr <= wr_ptr + 1'b1;
      if (rewind) rd_ptr <= '0;
      else if (out_valid && out_ready) rd_ptr <= rd_ptr + 1'b1;
    end
  end

  // Storage has no reset; stale words are never marked valid
  always_ff @(posedge clk) begin
    if (in_valid && in_ready) mem[wr_ptr[AW-1:0]] <= in_data;
  end
endmodule

//--- fifo_port_ctl.sv
// Port control of a FIFO with independent write and read ports.
// Assumes all port pins are asynchronous to mclk and slower than mclk / 4.
`timescale 1ns/1ps

// Functional notes
// - Full reset zeroes both pointers and the output data register.
// - While full reset is held, all static configuration pins are latched.
// - Partial reset zeroes pointers and output register, keeps mode and offsets.
// - Partial reset never changes timing mode, programming method or offsets.
// - Almost-empty low while count below empty offset, high otherwise.
// - Almost-full high while free space exceeds full offset, low otherwise.
// - Flag timing select low means asynchronous almost flags, high synchronous.
// - Retransmit select low means zero latency, high normal latency.
// - Retransmit rewinds read pointer, shows empty, leaves all else untouched.
// - Synchronous read edge with enable reads one word or an offset.
// - Offset access low makes reads return the offset registers.
// - Asynchronous read takes a word per strobe edge; reader ties enable low.
// - Synchronous write edge with enable stores the input word.
// - Asynchronous write stores per strobe edge; writer holds enable active.
// - Write enable also gates parallel loads of the offset registers.
// - Serial offset shifting happens only while serial load enable is active.
// - Output enable inactive floats the data outputs, active drives them.
// - Narrow read widths zero the upper output bits; selects pick width.
// - Shared pin picks fall-through in full reset if the read port is clocked, later carries serial data.
// - Status pin shows empty in standard mode, output ready in fall-through.
module fifo_port_ctl (
  input  wire logic                            mclk,                      // System clock, 50 MHz
  input  wire logic                            rst_n,                     // Synchronous reset, active low
  input  wire logic                            full_reset_n,              // Full reset pin
  input  wire logic                            partial_reset_n,           // Partial reset pin
  input  wire logic                            wclk,                      // Write clock or strobe pin
  input  wire logic                            write_enable_n,            // Write enable pin
  input  wire logic [fifo_ctl_pkg::DATA_W-1:0] write_data_in,             // Write data pins
  input  wire logic                            rclk,                      // Read clock or strobe pin
  input  wire logic                            read_enable_n,             // Read enable pin
  input  wire logic                            retransmit_n,              // Retransmit pin
  input  wire logic                            offset_access_n,           // Offset access pin
  input  wire logic                            serial_load_enable_n,      // Serial load enable pin
  input  wire logic                            fall_through_or_serial_in, // Mode or serial data pin
  input  wire logic                            output_enable_n,           // Output enable pin
  input  wire logic [1:0]                      flag_offset_sel,           // Default offset select pins
  input  wire logic                            flag_timing_select,        // Flag timing pin
  input  wire logic                            retransmit_timing_select,  // Retransmit latency pin
  input  wire logic                            bus_matching_sel,          // Bus matching pin
  input  wire logic                            write_port_width_sel,      // Write width pin
  input  wire logic                            read_port_width_sel,       // Read width pin
  input  wire logic                            big_endian_n,              // Byte order pin
  input  wire logic                            parity_sel,                // Parity placement pin
  input  wire logic                            sync_read_sel,             // High: clocked read port
  input  wire logic                            sync_write_sel,            // High: clocked write port
  output logic [fifo_ctl_pkg::DATA_W-1:0]      read_data_out,             // Read data pins
  output logic                                 read_data_oe,              // High while pins are driven
  output logic                                 empty_or_output_ready,     // Empty flag or output ready
  output logic                                 full_or_input_ready,       // Full flag or input ready
  output logic                                 half_full_n,               // Low when over half full
  output logic                                 almost_empty_flag,         // Almost-empty flag
  output logic                                 almost_full_flag           // Almost-full flag
);
  localparam int PW = $bits(fifo_ctl_pkg::pins_t);

  // ----------------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------------
  fifo_ctl_pkg::pins_t pin_raw;
  fifo_ctl_pkg::pins_t pin;
  logic [PW-1:0]       sync1;
  logic [PW-1:0]       sync2;
  logic [PW-1:0]       sync3;
  logic [PW-1:0]       filt;
  logic [PW-1:0]       agree;

  assign pin_raw.full_reset_n              = full_reset_n;
  assign pin_raw.partial_reset_n           = partial_reset_n;
  assign pin_raw.wclk                      = wclk;
  assign pin_raw.wen_n                     = write_enable_n;
  assign pin_raw.wdata                     = write_data_in;
  assign pin_raw.rclk                      = rclk;
  assign pin_raw.ren_n                     = read_enable_n;
  assign pin_raw.retransmit_n              = retransmit_n;
  assign pin_raw.offset_access_n           = offset_access_n;
  assign pin_raw.serial_load_enable_n      = serial_load_enable_n;
  assign pin_raw.fall_through_or_serial_in = fall_through_or_serial_in;
  assign pin_raw.oe_n                      = output_enable_n;
  assign pin_raw.fsel                      = flag_offset_sel;
  assign pin_raw.flag_timing_select        = flag_timing_select;
  assign pin_raw.retransmit_timing_select  = retransmit_timing_select;
  assign pin_raw.bus_matching_sel          = bus_matching_sel;
  assign pin_raw.write_port_width_sel      = write_port_width_sel;
  assign pin_raw.read_port_width_sel       = read_port_width_sel;
  assign pin_raw.big_endian_n              = big_endian_n;
  assign pin_raw.parity_sel                = parity_sel;
  assign pin_raw.sync_read_sel             = sync_read_sel;
  assign pin_raw.sync_write_sel            = sync_write_sel;

  // A bit moves on only when stages two and three agree
  assign agree = ~(sync2 ^ sync3);
  assign pin   = fifo_ctl_pkg::pins_t'(filt);

  // Three-stage sampler; data rides with its clock so they stay aligned
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      filt  <= '0;
    end else begin
      sync1 <= pin_raw;
      sync2 <= sync1;
      sync3 <= sync2;
      filt  <= (agree & sync3) | (~agree & filt);
    end
  end

  // ----------------------------------------------------------------------
  // Port clock edges and commands
  // ----------------------------------------------------------------------
  fifo_ctl_pkg::cfg_t cfg;
  logic wclk_d;
  logic rclk_d;
  logic w_edge;
  logic r_edge;
  logic in_full_reset;
  logic in_part_reset;
  logic any_reset;
  logic wr_go;
  logic rd_go;
  logic rt_go;
  logic ofs_sel;
  logic ofs_wr;
  logic ofs_rd;
  logic mem_wr;
  logic ser_shift;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wclk_d <= 1'b0;
      rclk_d <= 1'b0;
    end else begin
      wclk_d <= pin.wclk;
      rclk_d <= pin.rclk;
    end
  end

  assign w_edge        = pin.wclk & ~wclk_d;
  assign r_edge        = pin.rclk & ~rclk_d;
  assign in_full_reset = ~pin.full_reset_n;
  assign in_part_reset = ~pin.partial_reset_n;
  assign any_reset     = in_full_reset | in_part_reset;
  assign ofs_sel       = ~pin.offset_access_n;
  assign wr_go = w_edge & ~any_reset & (cfg.async_write | ~pin.wen_n);
  assign rd_go = r_edge & ~any_reset & (cfg.async_read | ~pin.ren_n);
  assign rt_go = r_edge & ~any_reset & ~pin.retransmit_n;
  assign ofs_wr = wr_go & ofs_sel & ~cfg.serial_prog;
  assign ofs_rd = rd_go & ofs_sel & ~rt_go;
  assign mem_wr = wr_go & ~ofs_sel;
  assign ser_shift = w_edge & ~any_reset & ~pin.serial_load_enable_n & cfg.serial_prog;

  // ----------------------------------------------------------------------
  // Configuration latch
  // ----------------------------------------------------------------------
  fifo_ctl_pkg::cfg_t next_cfg;

  assign next_cfg = '{
    fall_through_mode:    pin.fall_through_or_serial_in & pin.sync_read_sel,
    serial_prog:          pin.offset_access_n,
    sync_flags:           pin.flag_timing_select,
    normal_rt:            pin.retransmit_timing_select,
    bus_matching_sel:     pin.bus_matching_sel,
    write_port_width_sel: pin.write_port_width_sel,
    read_port_width_sel:  pin.read_port_width_sel,
    big_endian_n:         pin.big_endian_n,
    parity_sel:           pin.parity_sel,
    async_read:           ~pin.sync_read_sel,
    async_write:          ~pin.sync_write_sel
  };

  // pins read only during full reset
  always_ff @(posedge mclk) begin
    if (!rst_n) cfg <= fifo_ctl_pkg::CFG_RESET;
    else if (in_full_reset) cfg <= next_cfg;
  end

  // ----------------------------------------------------------------------
  // Threshold offsets
  // ----------------------------------------------------------------------
  logic [fifo_ctl_pkg::OFS_W-1:0] empty_ofs;
  logic [fifo_ctl_pkg::OFS_W-1:0] full_ofs;
  logic                           ofs_wr_sel;   // 0: empty offset next
  logic                           ofs_rd_sel;
  logic [2:0]                     dflt_idx;

  assign dflt_idx = {pin.offset_access_n, pin.fsel};

  // Parallel loads alternate empty then full; serial shifts both as one word
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      empty_ofs  <= fifo_ctl_pkg::DEFAULT_OFS[0];
      full_ofs   <= fifo_ctl_pkg::DEFAULT_OFS[0];
      ofs_wr_sel <= 1'b0;
    end else if (in_full_reset) begin
      empty_ofs  <= fifo_ctl_pkg::DEFAULT_OFS[dflt_idx];
      full_ofs   <= fifo_ctl_pkg::DEFAULT_OFS[dflt_idx];
      ofs_wr_sel <= 1'b0;
    end else if (in_part_reset) begin
      ofs_wr_sel <= 1'b0;
    end else if (ser_shift) begin
      {full_ofs, empty_ofs} <= {full_ofs[fifo_ctl_pkg::OFS_W-2:0], empty_ofs,
                                pin.fall_through_or_serial_in};
    end else if (ofs_wr) begin
      if (ofs_wr_sel) full_ofs <= pin.wdata[fifo_ctl_pkg::OFS_W-1:0];
      else empty_ofs <= pin.wdata[fifo_ctl_pkg::OFS_W-1:0];
      ofs_wr_sel <= ~ofs_wr_sel;
    end
  end

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  logic                             fifo_in_ready;
  logic                             fifo_out_valid;
  logic                             pop;
  logic [fifo_ctl_pkg::DATA_W-1:0]  fifo_out_data;
  logic [fifo_ctl_pkg::DATA_W-1:0]  wdata_masked;
  logic [fifo_ctl_pkg::LVL_W-1:0]   level;
  logic                             out_valid;
  logic                             rt_hold;
  logic                             word_read;
  logic                             prefetch;

  // Unused lanes of a narrow write port are stored as zero
  assign wdata_masked = !cfg.bus_matching_sel ? pin.wdata :
                        cfg.write_port_width_sel ?
                        fifo_ctl_pkg::DATA_W'(pin.wdata[fifo_ctl_pkg::NINE_W-1:0]) :
                        fifo_ctl_pkg::DATA_W'(pin.wdata[fifo_ctl_pkg::HALF_W-1:0]);

  word_fifo #(
    .W  (fifo_ctl_pkg::DATA_W),
    .D  (fifo_ctl_pkg::DEPTH),
    .AW (fifo_ctl_pkg::PTR_W)
  ) u_store (
    .clk       (mclk),
    .rst_n     (rst_n),
    .clear     (any_reset),
    .rewind    (rt_go),
    .in_valid  (mem_wr),
    .in_ready  (fifo_in_ready),
    .in_data   (wdata_masked),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (fifo_out_data),
    .level     (level)
  );

  // Fall-through fetches on its own; standard waits for a read edge
  assign word_read = rd_go & ~ofs_sel & ~rt_go;
  assign prefetch  = cfg.fall_through_mode & ~out_valid & ~rt_hold & ~rt_go & ~any_reset;
  assign pop       = fifo_out_valid & (word_read | prefetch);

  // ----------------------------------------------------------------------
  // Output register
  // ----------------------------------------------------------------------
  logic [fifo_ctl_pkg::DATA_W-1:0] next_out;
  logic [fifo_ctl_pkg::DATA_W-1:0] ofs_word;

  assign ofs_word = fifo_ctl_pkg::DATA_W'(ofs_rd_sel ? full_ofs : empty_ofs);
  assign next_out = !cfg.bus_matching_sel ? fifo_out_data :
                    cfg.read_port_width_sel ?
                    fifo_ctl_pkg::DATA_W'(fifo_out_data[fifo_ctl_pkg::NINE_W-1:0]) :
                    fifo_ctl_pkg::DATA_W'(fifo_out_data[fifo_ctl_pkg::HALF_W-1:0]);

  // normal latency waits a read edge
  always_ff @(posedge mclk) begin
    if (!rst_n || any_reset) begin
      read_data_out <= fifo_ctl_pkg::OUT_RESET;
      out_valid     <= 1'b0;
      rt_hold       <= 1'b0;
      ofs_rd_sel    <= 1'b0;
    end else if (rt_go) begin
      out_valid <= 1'b0;
      rt_hold   <= cfg.normal_rt;
    end else begin
      if (r_edge) rt_hold <= 1'b0;
      if (ofs_rd) begin
        read_data_out <= ofs_word;
        ofs_rd_sel    <= ~ofs_rd_sel;
      end else if (pop) begin
        read_data_out <= next_out;
        out_valid     <= 1'b1;
      end else if (word_read) begin
        out_valid <= 1'b0;
      end
    end
  end

  assign read_data_oe = ~pin.oe_n;

  // ----------------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------------
  logic [fifo_ctl_pkg::TOT_W-1:0] total;
  logic [fifo_ctl_pkg::LVL_W-1:0] free_cnt;
  logic                           next_ae;
  logic                           next_af;
  logic                           ae_upd;
  logic                           af_upd;

  // The word held at the outputs in fall-through still counts as stored
  assign total    = fifo_ctl_pkg::TOT_W'(level) +
                    fifo_ctl_pkg::TOT_W'(cfg.fall_through_mode & out_valid);
  assign free_cnt = fifo_ctl_pkg::DEPTH_LVL - level;
  assign next_ae  = total >= fifo_ctl_pkg::TOT_W'(empty_ofs);
  assign next_af  = free_cnt > fifo_ctl_pkg::LVL_W'(full_ofs);
  // synchronous flags follow the port clocks
  assign ae_upd   = ~cfg.sync_flags | r_edge | any_reset;
  assign af_upd   = ~cfg.sync_flags | w_edge | any_reset;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      empty_or_output_ready <= 1'b0;
      full_or_input_ready   <= 1'b1;
      half_full_n           <= 1'b1;
      almost_empty_flag     <= 1'b0;
      almost_full_flag      <= 1'b1;
    end else begin
      empty_or_output_ready <= cfg.fall_through_mode ? ~out_valid : fifo_out_valid & ~rt_go;
      full_or_input_ready   <= cfg.fall_through_mode ? ~fifo_in_ready : fifo_in_ready;
      half_full_n           <= level <= fifo_ctl_pkg::HALF_LVL;
      if (ae_upd) almost_empty_flag <= next_ae;
      if (af_upd) almost_full_flag <= next_af;
    end
  end

endmodule

//--- fifo_port_ctl_props.sv
// Checker on the FIFO port control top ports.
// Assumes pins reach the logic within a few mclk cycles.
`timescale 1ns/1ps
module fifo_port_ctl_props (
  input wire logic        mclk,                   // Clock
  input wire logic        rst_n,                  // Reset
  input wire logic        full_reset_n,           // Full reset pin
  input wire logic        partial_reset_n,        // Partial reset pin
  input wire logic        wclk,                   // Write clock pin
  input wire logic        rclk,                   // Read clock pin
  input wire logic        output_enable_n,        // Output enable pin
  input wire logic [35:0] read_data_out,          // Read data
  input wire logic        read_data_oe,           // Data drive
  input wire logic        empty_or_output_ready,  // Empty flag
  input wire logic        full_or_input_ready,    // Full flag
  input wire logic        almost_empty_flag,      // Almost empty
  input wire logic        almost_full_flag        // Almost full
);
  logic       wr_q;
  logic       rd_q;
  logic [3:0] quiet;  // Cycles since a port edge or reset
  wire        stir = !rst_n || !full_reset_n || !partial_reset_n || (wclk && !wr_q) || (rclk && !rd_q);
  // Outputs may only move shortly after something caused it
  always_ff @(posedge mclk) begin
    wr_q  <= wclk;
    rd_q  <= rclk;
    quiet <= stir ? 4'h0 : (quiet == 4'hF ? quiet : quiet + 4'h1);
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  full_clr_a: assert property (!full_reset_n [*8] |=> read_data_out == 36'h0_0000_0000)
    else $error("data not cleared by full reset");
  part_clr_a: assert property (!partial_reset_n [*8] |=> read_data_out == 36'h0_0000_0000)
    else $error("data not cleared by partial reset");
  oe_on_a: assert property ($fell(output_enable_n) |-> ##[2:6] read_data_oe)
    else $error("data pins not driven");
  oe_off_a: assert property ($rose(output_enable_n) |-> ##[2:6] !read_data_oe)
    else $error("data pins not released");
  data_cause_a: assert property ($changed(read_data_out) |-> quiet < 4'hC)
    else $error("data changed without a read");
  ae_cause_a: assert property ($changed(almost_empty_flag) |-> quiet < 4'hC)
    else $error("almost empty moved without cause");
  af_cause_a: assert property ($changed(almost_full_flag) |-> quiet < 4'hC)
    else $error("almost full moved without cause");
  ef_cause_a: assert property ($changed(empty_or_output_ready) |-> quiet < 4'hC)
    else $error("empty flag moved without cause");
  ff_cause_a: assert property ($changed(full_or_input_ready) |-> quiet < 4'hC)
    else $error("full flag moved without cause");
  cover property ($fell(full_or_input_ready));
  cover property ($rose(almost_empty_flag));
  cover property ($fell(read_data_oe));
endmodule
bind fifo_port_ctl fifo_port_ctl_props props_i (.mclk, .rst_n, .full_reset_n, .partial_reset_n, .wclk,
  .rclk, .output_enable_n, .read_data_out, .read_data_oe, .empty_or_output_ready, .full_or_input_ready,
  .almost_empty_flag, .almost_full_flag);

//--- port_partner.sv
// External writer and reader: one port clock frame per call.
// Assumes the bench sets data and retransmit before each frame.
`timescale 1ns/1ps
module port_partner (
  output logic wclk,            // Write clock pin
  output logic rclk,            // Read clock pin
  output logic write_enable_n,  // Write enable pin
  output logic read_enable_n    // Read enable pin
);
  // Clocks rest low between frames, not free running
  initial {wclk, rclk, write_enable_n, read_enable_n} = 4'h3;
  task automatic put(input logic en);
    // Move off the mclk edge so the pin sampler never races us
    #1 write_enable_n = !en;
    #2 wclk = 1'b1;
    #80 wclk = 1'b0;
    #76 write_enable_n = 1'b1;
  endtask
  task automatic get(input logic en);
    #1 read_enable_n = !en;
    #2 rclk = 1'b1;
    #80 rclk = 1'b0;
    #76 read_enable_n = 1'b1;
  endtask
endmodule

//--- testbench.sv
// Self-checking bench for the FIFO port control.
// Assumes standard timing, clocked ports and default offsets.
`timescale 1ns/1ps
module testbench;
  localparam int OFS = fifo_ctl_pkg::DEFAULT_OFS[3];
  logic mclk, rst_n, full_reset_n, partial_reset_n, wclk, rclk, write_enable_n, read_enable_n, retransmit_n;
  logic offset_access_n, serial_load_enable_n, fall_through_or_serial_in, output_enable_n, flag_timing_select;
  logic retransmit_timing_select, bus_matching_sel, write_port_width_sel, read_port_width_sel, big_endian_n;
  logic parity_sel, sync_read_sel, sync_write_sel, read_data_oe, empty_or_output_ready, full_or_input_ready;
  logic half_full_n, almost_empty_flag, almost_full_flag;
  logic [1:0] flag_offset_sel;
  logic [fifo_ctl_pkg::DATA_W-1:0] write_data_in, read_data_out;
  int error_cnt, num_checks;
  fifo_port_ctl fifo_port_ctl_i (.*);
  port_partner port_partner_i (.*);
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [35:0] d, input logic en);
    @(posedge mclk) write_data_in <= d;
    port_partner_i.put(en);
    repeat (2) @(posedge mclk);
    #1;
  endtask
  task automatic rd(input logic en);
    @(posedge mclk);
    port_partner_i.get(en);
    repeat (2) @(posedge mclk);
    #1;
  endtask
  task automatic lvl(input int c);
    chk("empty flag", c != 0, empty_or_output_ready);
    chk("full flag", c != 8, full_or_input_ready);
    chk("almost empty", c >= OFS, almost_empty_flag);
    chk("almost full", 8 - c > OFS, almost_full_flag);
    chk("half full", c <= 4, half_full_n);
  endtask
  // Fill past full, then drain past empty
  task automatic t_fill;
    wr(36'h0_0000_00FF, 1'b0);
    lvl(0);
    for (int i = 0; i < 9; i++) begin
      wr(36'h0_0000_0010 + 36'(i), 1'b1);
      lvl(i < 8 ? i + 1 : 8);
    end
    rd(1'b0);
    chk("gated read", 36'h0_0000_0000, read_data_out);
    for (int i = 0; i < 9; i++) begin
      rd(1'b1);
      chk("read word", 36'h0_0000_0010 + 36'(i < 8 ? i : 7), read_data_out);
      lvl(i < 8 ? 7 - i : 0);
    end
  endtask
  // Offset access, with a disabled offset write before it
  task automatic t_offset;
    offset_access_n <= 1'b0;
    wr(36'h0_0000_0005, 1'b0);
    rd(1'b1);
    chk("offset read", 36'(OFS), read_data_out);
    offset_access_n <= 1'b1;
  endtask
  // Partial reset keeps offsets, then retransmit rereads
  task automatic t_rewind;
    @(posedge mclk) partial_reset_n <= 1'b0;
    repeat (10) @(posedge mclk);
    partial_reset_n <= 1'b1;
    repeat (8) @(posedge mclk);
    #1 chk("partial clear", 36'h0_0000_0000, read_data_out);
    for (int i = 0; i < 3; i++) wr(36'h0_0000_0020 + 36'(i), 1'b1);
    lvl(3);
    rd(1'b1);
    @(posedge mclk) retransmit_n <= 1'b0;
    rd(1'b1);
    retransmit_n <= 1'b1;
    rd(1'b1);
    chk("reread word", 36'h0_0000_0020, read_data_out);
    lvl(2);
  endtask
  // Output drive follows the enable
  task automatic t_oe;
    @(posedge mclk) output_enable_n <= 1'b1;
    repeat (8) @(posedge mclk);
    #1 chk("output drive", 1'b0, read_data_oe);
    output_enable_n <= 1'b0;
    repeat (8) @(posedge mclk);
    #1 chk("output drive", 1'b1, read_data_oe);
  endtask
  initial begin
    {rst_n, full_reset_n, partial_reset_n, retransmit_n, serial_load_enable_n, output_enable_n} = 6'h0E;
    offset_access_n = 1'b0;
    {fall_through_or_serial_in, flag_timing_select, retransmit_timing_select, bus_matching_sel} = 4'h0;
    {write_port_width_sel, read_port_width_sel, big_endian_n, parity_sel} = 4'h2;
    // config pins never move after this
    {sync_read_sel, sync_write_sel, flag_offset_sel} = 4'hF;
    write_data_in = 36'h0_0000_0000;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (10) @(posedge mclk);
    full_reset_n <= 1'b1;
    repeat (2) @(posedge mclk);
    offset_access_n <= 1'b1;
    repeat (8) @(posedge mclk);
    t_fill;
    t_offset;
    t_rewind;
    t_oe;
    end_sim;
  end
  // Cut a hang short
  initial begin
    repeat (50000) @(posedge mclk);
    error_cnt++;
    end_sim;
  end
endmodule
